// file: rtl/auth_message_exchange.sv
// Portable-side authentication message handler: builds, parses, sequences.
// Assumes byte streams to and from the link, external crypto and a MAC below.
//
// Summary of operation
// RULE_01: Requests carry message type 01000000.
// RULE_02: Replies carry 01000001 with response elements.
// RULE_03: Type MSB zero; other class ignored.
// RULE_04: Requests carry auth-kind plus challenge elements.
// RULE_05: Portable requests never carry response elements.
// RULE_06: Element codes: challenge, response, seed, auth-kind.
// RULE_07: Element totals: ten, six, ten, five bytes.
// RULE_08: Value MSB in bit 8, octet 3.
// RULE_09: Value LSB in last octet, descending order.
// RULE_10: Fixed side sends seed and challenge request.
// RULE_11: Portable answers request with first response.
// RULE_12: Fixed side drops call on mismatch.
// RULE_13: Portable sends own challenge in request.
// RULE_14: Fixed side replies seed and second response.
// RULE_15: Portable compares second response, drops on mismatch.
// RULE_16: Re-keying derives key via portable authentication.
// RULE_17: Stored default key allows immediate encryption.
// RULE_18: Default key named by system-wide index.
// RULE_19: Derived key replaces default key once ready.
// RULE_20: Unknown elements skipped using length octet.
`timescale 1ns/1ps
`include "auth_cfg.svh"

module auth_message_exchange
    import auth_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    // Command
    input  wire logic        start_in,
    input  wire logic [23:0] auth_kind_in,
    // Receive stream
    input  wire logic        rx_valid_in,
    input  wire logic [7:0]  rx_byte_in,
    input  wire logic        rx_last_in,
    output logic             rx_ready_out,
    // Transmit stream
    output logic             tx_valid_out,
    output logic [7:0]       tx_byte_out,
    output logic             tx_last_out,
    input  wire logic        tx_ready_in,
    // Crypto computation
    output logic             calc_req_out,
    output logic             xres_req_out,
    output logic [63:0]      seed_out,
    output logic [63:0]      chal_out,
    input  wire logic        calc_done_in,
    input  wire logic [31:0] first_response_in,
    input  wire logic [63:0] derived_key_in,
    input  wire logic        xres_done_in,
    input  wire logic [31:0] expected_second_response_in,
    // Result
    output logic             busy_out,
    output logic             auth_ok_out,
    output logic             drop_call_out,
    // Cipher key to link layer
    input  wire logic        store_default_in,
    input  wire logic [7:0]  default_index_in,
    output logic [63:0]      cipher_key_out,
    output logic [7:0]       key_index_out,
    output logic             default_valid_out,
    output logic             rekey_out
);

    // ****************************************
    // Element decode
    // ****************************************
    function automatic logic [7:0] content_len(input logic [7:0] ei);
        case (ei)
            `AUTH_EI_CHAL: content_len = `AUTH_LEN_CHAL - `AUTH_LEN_HDR;
            `AUTH_EI_SEED: content_len = `AUTH_LEN_SEED - `AUTH_LEN_HDR;
            `AUTH_EI_RESP: content_len = `AUTH_LEN_RESP - `AUTH_LEN_HDR;
            `AUTH_EI_KIND: content_len = `AUTH_LEN_KIND - `AUTH_LEN_HDR;
            default:       content_len = 8'h00;
        endcase
    endfunction

    ctl_t  st_r;
    ctl_t  st_nxt;
    buf_if mb ();

    msg_buffer u_buf (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .bus        (mb.store)
    );

    assign mb.we    = st_r.wr_en;
    assign mb.waddr = st_r.wr_addr;
    assign mb.wdata = st_r.wr_data;
    assign mb.raddr = st_r.ptr[4:0];

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_nxt          = st_r;
        st_nxt.wr_en    = 1'b0;
        st_nxt.calc_req = 1'b0;
        st_nxt.xres_req = 1'b0;
        st_nxt.auth_ok  = 1'b0;
        st_nxt.drop     = 1'b0;
        st_nxt.rekey    = 1'b0;
        st_nxt.lfsr     = {1'b0, st_r.lfsr[63:1]} ^ (st_r.lfsr[0] ? `AUTH_LFSR_TAPS : 64'h0);

        // Capture of one incoming message
        if (rx_valid_in && st_r.rx_rdy) begin
            if (st_r.rx_cnt == `AUTH_BUF_DEPTH) begin
                st_nxt.ovf = 1'b1;
            end else begin
                st_nxt.wr_en   = 1'b1;
                st_nxt.wr_addr = st_r.rx_cnt[4:0];
                st_nxt.wr_data = rx_byte_in;
                st_nxt.rx_cnt  = st_r.rx_cnt + 6'h01;
            end
            if (rx_last_in) begin
                st_nxt.rx_rdy  = 1'b0;
                st_nxt.rx_done = 1'b1;
            end
        end

        case (st_r.state)
            S_IDLE: begin
                if (st_r.rx_done) begin
                    st_nxt.state = S_RD;
                    st_nxt.ptr   = 6'h00;
                    st_nxt.step  = P_TYPE;
                    st_nxt.bad   = 1'b0;
                    st_nxt.got   = 4'h0;
                end else if (start_in && !st_r.pend) begin
                    // Request with auth-kind and fresh challenge only [RULE_13] [RULE_05]
                    st_nxt.own_chal = st_r.lfsr;
                    st_nxt.tx_sh    = {`AUTH_MT_REQ,                                     // [RULE_01]
                                       `AUTH_EI_KIND, `AUTH_LEN_KIND - `AUTH_LEN_HDR,  // [RULE_04]
                                       auth_kind_in,
                                       `AUTH_EI_CHAL, `AUTH_LEN_CHAL - `AUTH_LEN_HDR,  // [RULE_06] [RULE_07]
                                       st_r.lfsr};                                      // [RULE_08] [RULE_09]
                    st_nxt.tx_len   = `AUTH_REQ_BYTES;
                    st_nxt.tx_rem   = `AUTH_REQ_BYTES;
                    st_nxt.tx_req   = 1'b1;
                    st_nxt.state    = S_TX;
                end
            end
            S_TX: begin
                if (!st_r.tx_valid || tx_ready_in) begin
                    if (st_r.tx_rem == 5'h00) begin
                        st_nxt.tx_valid = 1'b0;
                        st_nxt.tx_last  = 1'b0;
                        st_nxt.state    = S_IDLE;
                        if (st_r.tx_req) begin
                            st_nxt.pend = 1'b1;
                        end
                    end else begin
                        // Most significant byte first [RULE_08] [RULE_09]
                        st_nxt.tx_valid = 1'b1;
                        st_nxt.tx_byte  = st_r.tx_sh[127:120];
                        st_nxt.tx_sh    = {st_r.tx_sh[119:0], 8'h00};
                        st_nxt.tx_last  = (st_r.tx_rem == 5'h01);
                        st_nxt.tx_pos   = st_r.tx_len - st_r.tx_rem;
                        st_nxt.tx_rem   = st_r.tx_rem - 5'h01;
                    end
                end
            end
            S_RD: begin
                st_nxt.state = S_USE;
            end
            S_USE: begin
                st_nxt.ptr = st_r.ptr + 6'h01;
                case (st_r.step)
                    P_TYPE: begin
                        st_nxt.mtype = mb.rdata;
                        st_nxt.step  = P_EI;
                    end
                    P_EI: begin
                        st_nxt.ei   = mb.rdata;
                        st_nxt.step = P_LEN;
                    end
                    P_LEN: begin
                        // Unknown elements are counted off by length [RULE_20]
                        st_nxt.rem = mb.rdata;
                        if (content_len(st_r.ei) != 8'h00 && mb.rdata != content_len(st_r.ei)) begin
                            st_nxt.bad = 1'b1;  // [RULE_07]
                        end
                        st_nxt.step = (mb.rdata == 8'h00) ? P_EI : P_VAL;
                    end
                    P_VAL: begin
                        st_nxt.val = {st_r.val[55:0], mb.rdata};  // [RULE_08] [RULE_09]
                        st_nxt.rem = st_r.rem - 8'h01;
                        if (st_r.rem == 8'h01) begin
                            st_nxt.step = P_EI;
                            case (st_r.ei)
                                `AUTH_EI_CHAL: begin
                                    st_nxt.rchal  = st_nxt.val;
                                    st_nxt.got[0] = 1'b1;
                                end
                                `AUTH_EI_SEED: begin
                                    st_nxt.seed   = st_nxt.val;
                                    st_nxt.got[1] = 1'b1;
                                end
                                `AUTH_EI_RESP: begin
                                    st_nxt.res    = st_nxt.val[31:0];
                                    st_nxt.got[2] = 1'b1;
                                end
                                `AUTH_EI_KIND: begin
                                    st_nxt.got[3] = 1'b1;
                                end
                                default: begin
                                    st_nxt.got = st_r.got;  // [RULE_20]
                                end
                            endcase
                        end
                    end
                    default: begin
                        st_nxt.step = P_EI;
                    end
                endcase
                if (st_nxt.ptr == st_r.rx_cnt) begin
                    st_nxt.state = S_DISP;
                    if (st_nxt.step != P_EI) begin
                        st_nxt.bad = 1'b1;
                    end
                end else begin
                    st_nxt.state = S_RD;
                end
            end
            S_DISP: begin
                st_nxt.rx_done = 1'b0;
                st_nxt.rx_rdy  = 1'b1;
                st_nxt.rx_cnt  = 6'h00;
                st_nxt.ovf     = 1'b0;
                st_nxt.state   = S_IDLE;
                // Other message class is not ours [RULE_03]
                if (!st_r.ovf && !st_r.bad && !st_r.mtype[`AUTH_CLASS_BIT]) begin
                    if (st_r.mtype == `AUTH_MT_REQ && st_r.got[3] && st_r.got[1] && st_r.got[0]) begin
                        // Fixed-side request: kind, seed, challenge [RULE_04] [RULE_11]
                        st_nxt.seed_o   = st_r.seed;
                        st_nxt.chal_o   = st_r.rchal;
                        st_nxt.calc_req = 1'b1;
                        st_nxt.state    = S_CALC;
                    end else if (st_r.mtype == `AUTH_MT_REPLY && st_r.pend && st_r.got[1] && st_r.got[2]) begin
                        // Fixed-side reply: seed and second response [RULE_14] [RULE_02]
                        st_nxt.seed_o   = st_r.seed;
                        st_nxt.chal_o   = st_r.own_chal;
                        st_nxt.xres_req = 1'b1;
                        st_nxt.state    = S_CHECK;
                    end
                end
            end
            S_CALC: begin
                if (calc_done_in) begin
                    st_nxt.tx_sh  = {`AUTH_MT_REPLY,                                     // [RULE_02]
                                     `AUTH_EI_RESP, `AUTH_LEN_RESP - `AUTH_LEN_HDR,    // [RULE_06]
                                     first_response_in, 72'h0};                         // [RULE_11]
                    st_nxt.tx_len = `AUTH_REPLY_BYTES;
                    st_nxt.tx_rem = `AUTH_REPLY_BYTES;
                    st_nxt.tx_req = 1'b0;
                    st_nxt.state  = S_TX;
                    // New derived key takes over at once [RULE_16] [RULE_19]
                    st_nxt.key    = derived_key_in;
                    st_nxt.rekey  = 1'b1;
                    if (store_default_in) begin
                        st_nxt.key_idx   = default_index_in;  // [RULE_18]
                        st_nxt.def_valid = 1'b1;              // [RULE_17]
                    end
                end
            end
            S_CHECK: begin
                if (xres_done_in) begin
                    st_nxt.pend  = 1'b0;
                    st_nxt.state = S_IDLE;
                    if (expected_second_response_in == st_r.res) begin
                        st_nxt.auth_ok = 1'b1;
                    end else begin
                        st_nxt.drop = 1'b1;  // [RULE_15]
                    end
                end
            end
            default: begin
                st_nxt.state = S_IDLE;
            end
        endcase
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            st_r        <= '0;
            st_r.rx_rdy <= 1'b1;
            st_r.lfsr   <= `AUTH_LFSR_SEED;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rx_ready_out      = st_r.rx_rdy;
    assign tx_valid_out      = st_r.tx_valid;
    assign tx_byte_out       = st_r.tx_byte;
    assign tx_last_out       = st_r.tx_last;
    assign calc_req_out      = st_r.calc_req;
    assign xres_req_out      = st_r.xres_req;
    assign seed_out          = st_r.seed_o;
    assign chal_out          = st_r.chal_o;
    assign busy_out          = st_r.pend;
    assign auth_ok_out       = st_r.auth_ok;
    assign drop_call_out     = st_r.drop;
    assign cipher_key_out    = st_r.key;
    assign key_index_out     = st_r.key_idx;
    assign default_valid_out = st_r.def_valid;
    assign rekey_out         = st_r.rekey;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_mismatch;
        st_r.state == S_CHECK && xres_done_in && expected_second_response_in != st_r.res;
    endsequence

    sequence s_calc_done;
        st_r.state == S_CALC && calc_done_in;
    endsequence

    AST_TYPE_MSB: assert property (tx_valid_out && st_r.tx_pos == 5'h00 |-> !tx_byte_out[7]) // [RULE_03]
        else $error("message type msb not zero");
    AST_REQ_TYPE: assert property (tx_valid_out && st_r.tx_req && st_r.tx_pos == 5'h00 // [RULE_01]
                                   |-> tx_byte_out == `AUTH_MT_REQ)
        else $error("request type code wrong");
    AST_REPLY_TYPE: assert property (tx_valid_out && !st_r.tx_req && st_r.tx_pos == 5'h00 // [RULE_02]
                                     |-> tx_byte_out == `AUTH_MT_REPLY)
        else $error("reply type code wrong");
    AST_REQ_EI: assert property (tx_valid_out && st_r.tx_req && st_r.tx_pos inside {5'h01, 5'h06} // [RULE_06]
                                 |-> tx_byte_out == ((st_r.tx_pos == 5'h06) ? `AUTH_EI_CHAL : `AUTH_EI_KIND))
        else $error("request element codes wrong");
    AST_CHAL_MSB: assert property (tx_valid_out && st_r.tx_req && st_r.tx_pos == 5'h08 // [RULE_08]
                                   |-> tx_byte_out == st_r.own_chal[63:56])
        else $error("challenge msb octet misplaced");
    AST_CHAL_LSB: assert property (tx_valid_out && tx_last_out && st_r.tx_req // [RULE_09]
                                   |-> st_r.tx_pos == 5'h0F && tx_byte_out == st_r.own_chal[7:0])
        else $error("challenge lsb octet misplaced");
    AST_REPLY_LEN: assert property (tx_valid_out && tx_last_out && !st_r.tx_req |-> st_r.tx_pos == 5'h06) // [RULE_07]
        else $error("reply length wrong");
    AST_DROP: assert property (s_mismatch |=> drop_call_out && !auth_ok_out ##1 !drop_call_out) // [RULE_15]
        else $error("mismatch did not drop call");
    AST_REKEY: assert property (s_calc_done |=> rekey_out && cipher_key_out == $past(derived_key_in) // [RULE_16]
                                ##1 tx_valid_out && tx_byte_out == `AUTH_MT_REPLY)
        else $error("derived key or reply missing");

endmodule

// file: rtl/auth_cfg.svh
// Codes, element lengths and constants of the authentication message handler.
// Assumes it is included by bare name; definitions only.
`ifndef AUTH_CFG_SVH
`define AUTH_CFG_SVH

`define AUTH_MT_REQ       8'h40
`define AUTH_MT_REPLY     8'h41
`define AUTH_CLASS_BIT    7
`define AUTH_EI_CHAL      8'h0C
`define AUTH_EI_RESP      8'h0D
`define AUTH_EI_SEED      8'h0E
`define AUTH_EI_KIND      8'h0A
`define AUTH_LEN_CHAL     8'h0A
`define AUTH_LEN_RESP     8'h06
`define AUTH_LEN_SEED     8'h0A
`define AUTH_LEN_KIND     8'h05
`define AUTH_LEN_HDR      8'h02
`define AUTH_REQ_BYTES    5'h10
`define AUTH_REPLY_BYTES  5'h07
`define AUTH_BUF_AW       5
`define AUTH_BUF_DEPTH    6'h20
`define AUTH_LFSR_SEED    64'hA5C3_0F1E_9B7D_2468
`define AUTH_LFSR_TAPS    64'hD800_0000_0000_0000

`endif

// file: rtl/auth_pkg.sv
// Types of the authentication message handler.
// Assumes auth_cfg.svh is on the include path.
`include "auth_cfg.svh"

package auth_pkg;

    typedef enum logic [2:0] {S_IDLE, S_TX, S_RD, S_USE, S_DISP, S_CALC, S_CHECK} fsm_t;
    typedef enum logic [1:0] {P_TYPE, P_EI, P_LEN, P_VAL} step_t;

    typedef struct packed {
        fsm_t          state;
        step_t         step;
        logic          rx_rdy;
        logic          rx_done;
        logic          ovf;
        logic [5:0]    rx_cnt;
        logic          wr_en;
        logic [4:0]    wr_addr;
        logic [7:0]    wr_data;
        logic [5:0]    ptr;
        logic [7:0]    mtype;
        logic [7:0]    ei;
        logic [7:0]    rem;
        logic [63:0]   val;
        logic          bad;
        logic [3:0]    got;
        logic [63:0]   seed;
        logic [63:0]   rchal;
        logic [31:0]   res;
        logic [63:0]   own_chal;
        logic [63:0]   lfsr;
        logic          pend;
        logic [127:0]  tx_sh;
        logic [4:0]    tx_len;
        logic [4:0]    tx_rem;
        logic [4:0]    tx_pos;
        logic          tx_req;
        logic          tx_valid;
        logic [7:0]    tx_byte;
        logic          tx_last;
        logic          calc_req;
        logic          xres_req;
        logic [63:0]   seed_o;
        logic [63:0]   chal_o;
        logic          auth_ok;
        logic          drop;
        logic [63:0]   key;
        logic [7:0]    key_idx;
        logic          def_valid;
        logic          rekey;
    } ctl_t;

    typedef struct packed {
        logic [(1 << `AUTH_BUF_AW)-1:0][7:0] mem;
        logic [7:0]                          q;
    } buf_t;

endpackage

// file: rtl/buf_if.sv
// Write and read port between the handler and its message buffer.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`include "auth_cfg.svh"

interface buf_if;
    logic                    we;
    logic [`AUTH_BUF_AW-1:0] waddr;
    logic [7:0]              wdata;
    logic [`AUTH_BUF_AW-1:0] raddr;
    logic [7:0]              rdata;

    modport owner (output we, output waddr, output wdata, output raddr, input rdata);
    modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// file: rtl/msg_buffer.sv
// Message byte buffer with registered read data.
// Assumes synchronous active-low reset and one clock.
`timescale 1ns/1ps
`include "auth_cfg.svh"

module msg_buffer
    import auth_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rst_n_in,
    // Buffer port
    buf_if.store      bus
);

    buf_t r;
    buf_t nxt;

    always_comb begin
        nxt = r;
        if (bus.we) begin
            nxt.mem[bus.waddr] = bus.wdata;
        end
        nxt.q = r.mem[bus.raddr];
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign bus.rdata = r.q;

endmodule

// file: verification/fixed_side_model.sv
// Fixed-side peer: sends requests and replies, takes the handler's bytes.
// Assumes one clock; its tasks are called just after a rising edge.
`timescale 1ns/1ps
module fixed_side_model (
    // Clock
    input  wire logic       clk_sys_in,
    // Stream into the handler
    output logic            rx_valid_out,
    output logic [7:0]      rx_byte_out,
    output logic            rx_last_out,
    input  wire logic       rx_ready_in,
    // Stream out of the handler
    input  wire logic       tx_valid_in,
    input  wire logic [7:0] tx_byte_in,
    input  wire logic       tx_last_in,
    output logic            tx_ready_out
);
    // ************************************
    // Message building and sending
    // ************************************
    logic [7:0] msg[$];
    logic [7:0] got[$];
    int         fails;
    logic       drop_call;
    initial begin
        rx_valid_out = 1'b0;
        rx_byte_out  = 8'h00;
        rx_last_out  = 1'b0;
        tx_ready_out = 1'b0;
        fails        = 0;
        drop_call    = 1'b0;
    end
    logic       take = 1'b0, take_last = 1'b0;
    logic [7:0] take_byte = 8'h00;
    int         last_at = 0;
    always begin
        @(posedge clk_sys_in);
        if (take) begin
            got.push_back(take_byte);
            if (take_last) last_at = got.size();
        end
        #1;
        tx_ready_out = ($urandom_range(3) != 0);
        take      = tx_valid_in && tx_ready_out;
        take_last = tx_last_in;
        take_byte = tx_byte_in;
    end
    task automatic put_val(input logic [7:0] ei, input logic [63:0] v, input int nb);
        msg.push_back(ei);
        msg.push_back(nb[7:0]);
        for (int i = nb - 1; i >= 0; i--) begin
            msg.push_back(v[8*i +: 8]);
        end
    endtask
    task automatic send();
        int n;
        logic rdy;
        foreach (msg[i]) begin
            rx_valid_out = 1'b1;
            rx_byte_out  = msg[i];
            rx_last_out  = (i == msg.size() - 1);
            n = 0;
            do begin
                rdy = rx_ready_in;
                @(posedge clk_sys_in);
                n++;
            end while (!rdy && n < 500);
            if (n >= 500) fails++;
            #1;
        end
        rx_valid_out = 1'b0;
        rx_last_out  = 1'b0;
        rx_byte_out  = ~rx_byte_out;
        msg.delete();
    endtask
    task automatic send_req(input logic [7:0] mt, input logic [23:0] kind, input logic [63:0] sd,
                            input logic [63:0] ch);
        msg.push_back(mt);
        put_val(8'h0A, {40'h0, kind}, 3);
        put_val(8'h0E, sd, 8);
        put_val(8'h7B, 64'h5AC3, 2);
        put_val(8'h0C, ch, 8);
        send();
    endtask
    task automatic send_reply(input logic [63:0] sd, input logic [31:0] r2);
        msg.push_back(8'h41);
        put_val(8'h0E, sd, 8);
        put_val(8'h0D, {32'h0, r2}, 4);
        send();
    endtask
    task automatic judge(input logic [31:0] expected_first_response);
        drop_call = ({got[3], got[4], got[5], got[6]} !== expected_first_response);
    endtask
endmodule

// file: verification/auth_message_exchange_tb_top.sv
// Self-checking bench of the portable-side authentication handler.
// Assumes auth_pkg, the design and fixed_side_model are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; $display("BAD %0t value mismatch", $time); end end
module auth_message_exchange_tb_top;
    // ************************************
    // Stimulus and checks
    // ************************************
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, start_in = 1'b0, calc_done_in = 1'b0, xres_done_in = 1'b0;
    logic store_default_in = 1'b0, rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
    logic calc_req, xres_req, busy, ok, drop, def_valid, rekey;
    logic [7:0] rx_byte, tx_byte, key_idx, default_index_in = 8'h00;
    logic [23:0] auth_kind_in = 24'h0;
    logic [31:0] first_response_in = 32'h0, expected_second_response_in = 32'h0;
    logic [63:0] derived_key_in = 64'h0, seed_o, chal_o, ckey, sd, ch;
    int err_total = 0, check_count = 0, n;
    always #12.5 clk_sys_in = ~clk_sys_in;
    auth_message_exchange uut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .start_in(start_in),
        .auth_kind_in(auth_kind_in), .rx_valid_in(rx_valid), .rx_byte_in(rx_byte), .rx_last_in(rx_last),
        .rx_ready_out(rx_ready), .tx_valid_out(tx_valid), .tx_byte_out(tx_byte), .tx_last_out(tx_last),
        .tx_ready_in(tx_ready), .calc_req_out(calc_req), .xres_req_out(xres_req), .seed_out(seed_o),
        .chal_out(chal_o), .calc_done_in(calc_done_in), .first_response_in(first_response_in),
        .derived_key_in(derived_key_in), .xres_done_in(xres_done_in),
        .expected_second_response_in(expected_second_response_in), .busy_out(busy), .auth_ok_out(ok),
        .drop_call_out(drop), .store_default_in(store_default_in), .default_index_in(default_index_in),
        .cipher_key_out(ckey), .key_index_out(key_idx), .default_valid_out(def_valid), .rekey_out(rekey));
    fixed_side_model peer (.clk_sys_in(clk_sys_in), .rx_valid_out(rx_valid), .rx_byte_out(rx_byte),
        .rx_last_out(rx_last), .rx_ready_in(rx_ready), .tx_valid_in(tx_valid), .tx_byte_in(tx_byte),
        .tx_last_in(tx_last), .tx_ready_out(tx_ready));
    function automatic logic [7:0] exp_req(input int i, input logic [23:0] k);
        logic [63:0] h;
        h = {8'h40, 8'h0A, 8'h03, k, 8'h0C, 8'h08};
        return h[63 - 8*i -: 8];
    endfunction
    function automatic logic [7:0] exp_rep(input int i, input logic [31:0] r);
        logic [55:0] h;
        h = {8'h41, 8'h0D, 8'h04, r};
        return h[55 - 8*i -: 8];
    endfunction
    task automatic step();
        @(posedge clk_sys_in);
        #1;
    endtask
    task automatic print_verdict();
        err_total += peer.fails;
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wait_for(input int sel, input int cnt);
        n = 0;
        while (!(sel == 0 ? calc_req : sel == 1 ? xres_req : peer.got.size() >= cnt) && n < 400) begin
            step();
            n++;
        end
        if (n >= 400) begin
            err_total++;
            print_verdict();
        end
    endtask
    initial begin
        void'($urandom(32'h8534));
        repeat (3) @(posedge clk_sys_in);
        #1;
        rst_n_in = 1'b1;
        `CHK({rx_ready, tx_valid, busy, def_valid, ckey}, {1'b1, 67'h0})
        sd = {$urandom, $urandom};
        ch = {$urandom, $urandom};
        peer.send_req(8'hC0, 24'($urandom), sd, ch);
        repeat (80) begin
            step();
            `CHK(calc_req | xres_req, 1'b0)
        end
        for (int j = 0; j < 2; j++) begin
            sd = {$urandom, $urandom};
            ch = (j == 0) ? 64'hFFFF_FFFF_FFFF_FFFF : {$urandom, $urandom};
            peer.got.delete();
            peer.send_req(8'h40, 24'($urandom), sd, ch);
            wait_for(0, 0);
            `CHK({seed_o, chal_o}, {sd, ch})
            first_response_in = $urandom;
            derived_key_in = {$urandom, $urandom};
            store_default_in = (j == 0);
            if (j == 0) default_index_in = 8'($urandom);
            calc_done_in = 1'b1;
            step();
            calc_done_in = 1'b0;
            `CHK({rekey, ckey, def_valid}, {1'b1, derived_key_in, 1'b1})
            `CHK(key_idx, default_index_in)
            wait_for(2, 7);
            for (int i = 0; i < 7; i++) `CHK(peer.got[i], exp_rep(i, first_response_in))
            `CHK(peer.last_at, 7)
            peer.judge(first_response_in);
            `CHK(peer.drop_call, 1'b0)
        end
        for (int k = 0; k < 2; k++) begin
            peer.got.delete();
            auth_kind_in = 24'($urandom);
            start_in = 1'b1;
            step();
            start_in = 1'b0;
            wait_for(2, 16);
            for (int i = 0; i < 8; i++) `CHK(peer.got[i], exp_req(i, auth_kind_in))
            `CHK(peer.last_at, 16)
            for (int i = 0; i < 8; i++) ch[63 - 8*i -: 8] = peer.got[8 + i];
            step();
            `CHK(busy, 1'b1)
            sd = {$urandom, $urandom};
            first_response_in = $urandom;
            peer.send_reply(sd, first_response_in);
            wait_for(1, 0);
            `CHK({seed_o, chal_o}, {sd, ch})
            expected_second_response_in = (k == 0) ? first_response_in : first_response_in ^ 32'h0000_0001;
            xres_done_in = 1'b1;
            step();
            xres_done_in = 1'b0;
            `CHK({ok, drop, busy}, {k == 0, k == 1, 1'b0})
        end
        print_verdict();
    end
endmodule
